// ===== hw/dsp_shift_addr.sv
// shifter, fraction/offset latches and sound-memory address generation
//
// Our own choices: register access over AXI4-Lite and the register offsets.
module dsp_shift_addr
    import dsp_addr_pkg::*;
#(
    parameter int ACC_W       = 26,
    parameter int ADDR_W      = 8,
    parameter int INIT_CYCLES = INIT_CYCLES_DEF
) (
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // instruction step
    input  wire logic                    step_valid,
    input  wire logic                    shift_ctl_hi,
    input  wire logic                    shift_ctl_lo,
    input  wire logic                    frac_latch_ctl,
    input  wire logic                    int_latch_ctl,
    input  wire logic                    offset_gate_bit,
    input  wire logic                    table_mode,
    input  wire logic                    next_word_increment,
    input  wire logic [MADR_W-1:0]       base_address_buffer,
    input  wire logic signed [ACC_W-1:0] accum_in,
    input  wire logic [OUT_W-1:0]        input_operand,
    input  wire logic                    sample_tick,
    // datapath results
    output logic [OUT_W-1:0]             shifter_output,
    output logic [FRAC_W-1:0]            fraction_reg,
    output logic [OFFS_W-1:0]            address_offset_reg,
    output logic [MADR_W-1:0]            mem_addr,
    output logic                         mem_addr_valid,
    output logic                         init_done,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [ADDR_W-1:0]       s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    localparam int INIT_W = $clog2(INIT_CYCLES + 1);

    // =====================================================
    // initialisation period
    logic [INIT_W-1:0] init_cnt_r;
    logic              init_done_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            init_cnt_r  <= '0;
            init_done_r <= 1'b0;
        end else if (!init_done_r) begin
            init_cnt_r  <= init_cnt_r + INIT_W'(1);
            init_done_r <= (init_cnt_r == INIT_W'(INIT_CYCLES - 1));
        end
    end

    wire step = step_valid & init_done_r;
    wire tick = sample_tick & init_done_r;

    // =====================================================
    // shifter
    shift_if #(.ACC_W(ACC_W)) sh_link ();

    assign sh_link.clk = clk;
    assign sh_link.acc = accum_in;
    assign sh_link.ctl = {shift_ctl_hi, shift_ctl_lo};

    dsp_out_shifter #(.ACC_W(ACC_W)) u_shifter (
        .sh (sh_link)
    );

    logic [OUT_W-1:0] shifter_output_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) shifter_output_r <= '0;
        else if (step) shifter_output_r <= sh_link.result;
    end

    // =====================================================
    // fraction and offset latches
    wire interp = shift_ctl_hi & shift_ctl_lo;

    wire [FRAC_W-1:0] frac_nxt = interp ?
        {1'b0, shifter_output_r[FRAC_W-2:0]} :
        shifter_output_r[FRAC_NI_LSB +: FRAC_W];
    wire [OFFS_W-1:0] offs_nxt = interp ?
        shifter_output_r[OFFS_IP_LSB +: OFFS_W] :
        {{(OFFS_W-OFFS_NI_BITS){input_operand[OUT_W-1]}},
         input_operand[OFFS_NI_LSB +: OFFS_NI_BITS]};

    logic [FRAC_W-1:0] fraction_reg_r;
    logic [OFFS_W-1:0] address_offset_reg_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) fraction_reg_r <= '0;
        else if (step && frac_latch_ctl) fraction_reg_r <= frac_nxt;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) address_offset_reg_r <= '0;
        else if (step && int_latch_ctl) address_offset_reg_r <= offs_nxt;
    end

    // =====================================================
    // sample down counter
    logic [1:0]        ring_len_r;
    logic [MADR_W-1:0] sample_down_counter_r;

    wire [MADR_W-1:0] ring_mask = {ring_len_r[1] & ring_len_r[0], ring_len_r[1],
                                   ring_len_r[1] | ring_len_r[0], RING_MASK_MIN};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) sample_down_counter_r <= '0;
        else if (tick) sample_down_counter_r <= (sample_down_counter_r == '0) ?
                                                 ring_mask : sample_down_counter_r - MADR_W'(1);
    end

    // =====================================================
    // address formation
    wire [MADR_W-1:0] off_ext  = {{(MADR_W-OFFS_W){address_offset_reg_r[OFFS_W-1]}}, address_offset_reg_r};
    wire [MADR_W-1:0] off_term = offset_gate_bit ? off_ext : '0;
    wire [MADR_W-1:0] cnt_term = table_mode ? '0 : sample_down_counter_r;
    wire [MADR_W-1:0] rel_sum  = base_address_buffer + off_term
                                 + {{(MADR_W-1){1'b0}}, next_word_increment};
    wire [MADR_W-1:0] rel_wrap = table_mode ? rel_sum : (rel_sum & ring_mask);
    wire [MADR_W-1:0] abs_sum  = rel_wrap + cnt_term;
    wire [MADR_W-1:0] addr_nxt = table_mode ? abs_sum : (abs_sum & ring_mask);

    logic [MADR_W-1:0] mem_addr_r;
    logic              mem_addr_valid_r;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_addr_r       <= '0;
            mem_addr_valid_r <= 1'b0;
        end else begin
            mem_addr_valid_r <= step;
            if (step) mem_addr_r <= addr_nxt;
        end
    end

    // =====================================================
    // AXI4-Lite write channel
    logic              aw_rdy_r, w_rdy_r, aw_hold_r, w_hold_r, bvalid_r;
    logic [1:0]        bresp_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;

    wire               aw_fire   = s_axi_awvalid & aw_rdy_r;
    wire               w_fire    = s_axi_wvalid & w_rdy_r;
    wire               aw_have   = aw_hold_r | aw_fire;
    wire               w_have    = w_hold_r | w_fire;
    wire               wr_do     = aw_have & w_have & ~bvalid_r;
    wire [ADDR_W-1:0]  wr_addr   = aw_hold_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0]        wr_data   = w_hold_r ? w_data_r : s_axi_wdata;
    wire [3:0]         wr_strb   = w_hold_r ? w_strb_r : s_axi_wstrb;
    wire [7:0]         wr_off    = {wr_addr[7:2], 2'b00};
    wire               wr_ctrl   = wr_do && (wr_off == REG_CTRL);
    wire               wr_known  = (wr_off == REG_CTRL) || (wr_off == REG_STATUS) || (wr_off == REG_FRACTION) ||
                                   (wr_off == REG_OFFSET) || (wr_off == REG_LAST_ADDR);
    wire               aw_hold_nxt = aw_have & ~wr_do;
    wire               w_hold_nxt  = w_have & ~wr_do;
    wire               bvalid_nxt  = wr_do | (bvalid_r & ~s_axi_bready);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_rdy_r  <= 1'b0;
            w_rdy_r   <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            aw_addr_r <= '0;
            w_data_r  <= '0;
            w_strb_r  <= '0;
        end else begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r  <= w_hold_nxt;
            aw_rdy_r  <= ~aw_hold_nxt & ~bvalid_nxt;
            w_rdy_r   <= ~w_hold_nxt & ~bvalid_nxt;
            bvalid_r  <= bvalid_nxt;
            if (wr_do) bresp_r <= (wr_known && init_done_r) ? RESP_OKAY : RESP_SLVERR;
            if (aw_fire) aw_addr_r <= s_axi_awaddr;
            if (w_fire) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) ring_len_r <= RING_LEN_RST;
        else if (wr_ctrl && wr_strb[0] && init_done_r) ring_len_r <= wr_data[1:0];
    end

    // =====================================================
    // AXI4-Lite read channel
    logic        ar_rdy_r, rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;

    wire         ar_fire    = s_axi_arvalid & ar_rdy_r;
    wire         rvalid_nxt = ar_fire | (rvalid_r & ~s_axi_rready);
    wire [7:0]   rd_off     = {s_axi_araddr[7:2], 2'b00};
    wire         rd_known   = (rd_off == REG_CTRL) || (rd_off == REG_STATUS) || (rd_off == REG_FRACTION) ||
                              (rd_off == REG_OFFSET) || (rd_off == REG_LAST_ADDR);
    wire [31:0]  rd_mux     =
        (rd_off == REG_CTRL)      ? {30'h0, ring_len_r} :
        (rd_off == REG_STATUS)    ? {sample_down_counter_r, 15'h0, init_done_r} :
        (rd_off == REG_FRACTION)  ? {19'h0, fraction_reg_r} :
        (rd_off == REG_OFFSET)    ? {20'h0, address_offset_reg_r} :
        (rd_off == REG_LAST_ADDR) ? {16'h0, mem_addr_r} : 32'h0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ar_rdy_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else begin
            ar_rdy_r <= ~rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_fire) begin
                rdata_r <= rd_mux;
                rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // =====================================================
    // outputs
    assign shifter_output     = shifter_output_r;
    assign fraction_reg       = fraction_reg_r;
    assign address_offset_reg = address_offset_reg_r;
    assign mem_addr           = mem_addr_r;
    assign mem_addr_valid     = mem_addr_valid_r;
    assign init_done          = init_done_r;
    assign s_axi_awready      = aw_rdy_r;
    assign s_axi_wready       = w_rdy_r;
    assign s_axi_bvalid       = bvalid_r;
    assign s_axi_bresp        = bresp_r;
    assign s_axi_arready      = ar_rdy_r;
    assign s_axi_rvalid       = rvalid_r;
    assign s_axi_rdata        = rdata_r;
    assign s_axi_rresp        = rresp_r;

    // =====================================================
    // checks
    a_sat_positive: assert property (@(posedge clk) disable iff (sys_rst)
        (step && !shift_ctl_hi && (sh_link.acc > 0) && sh_link.result[OUT_W-1]) |-> 0)
        else $error("saturated result wrapped negative");
    a_gain_raw: assert property (@(posedge clk) disable iff (sys_rst)
        (step && shift_ctl_hi && !shift_ctl_lo) |=> shifter_output_r == $past(accum_in[OUT_W-2:0]) * 2)
        else $error("unprotected x2 result wrong");
    a_frac_interp: assert property (@(posedge clk) disable iff (sys_rst)
        (step && frac_latch_ctl && interp) |=> fraction_reg_r[FRAC_W-1] == 1'b0 &&
        fraction_reg_r[FRAC_W-2:0] == $past(shifter_output_r[FRAC_W-2:0]))
        else $error("interpolation fraction wrong");
    a_frac_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !(step && frac_latch_ctl) |=> $stable(fraction_reg_r))
        else $error("fraction changed without latch");
    a_offs_sign: assert property (@(posedge clk) disable iff (sys_rst)
        (step && int_latch_ctl && !interp) |=> address_offset_reg_r[OFFS_W-1:OFFS_NI_BITS] ==
        {(OFFS_W-OFFS_NI_BITS){$past(input_operand[OUT_W-1])}})
        else $error("offset sign fill wrong");
    a_tbl_addr: assert property (@(posedge clk) disable iff (sys_rst)
        (step && table_mode && !offset_gate_bit) |=> mem_addr_r ==
        $past(base_address_buffer) + MADR_W'($past(next_word_increment)))
        else $error("table address not base plus increment");
    a_ring_bound: assert property (@(posedge clk) disable iff (sys_rst)
        (step && !table_mode) |=> (mem_addr_r & ~$past(ring_mask)) == '0)
        else $error("ring address outside ring");
    a_cnt_reload: assert property (@(posedge clk) disable iff (sys_rst)
        (tick && sample_down_counter_r == '0) |=> sample_down_counter_r == $past(ring_mask))
        else $error("counter did not reload");
    a_init_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !init_done_r |=> !mem_addr_valid_r)
        else $error("step taken during init");
endmodule : dsp_shift_addr

// ===== shared/dsp_addr_pkg.sv
// constants for the output shifter and sound-memory address datapath
// Contract
// - shift bits select gain and saturation
// - fractional latch loads the fraction register
// - integer latch loads the address-offset register
// - both shift bits set means interpolation
// - fraction source depends on interpolation mode
// - offset source: sign-filled operand or shifter
// - gate bit adds offset or nothing
// - ring mode wraps relative address at size
// - address is base plus offset plus counter
// - table mode never wraps, 64K words
// - roughly 30 ms initialisation after reset
// - counter decrements per sample, reloads at zero
// - table mode gates counter term to zero
// - gate bit zero gates offset to zero
// - ring length codes 8K to 64K words
package dsp_addr_pkg;
    // =====================================================
    // timing
    localparam int          CLK_KHZ          = 25000;
    localparam int          INIT_TIME_MS     = 30;
    localparam int          INIT_CYCLES_DEF  = INIT_TIME_MS * CLK_KHZ;
    // =====================================================
    // widths
    localparam int          OUT_W            = 24;
    localparam int          FRAC_W           = 13;
    localparam int          OFFS_W           = 12;
    localparam int          MADR_W           = 16;
    // =====================================================
    // shift control codes
    localparam logic [1:0]  SHIFT_X1_SAT     = 2'h0;
    localparam logic [1:0]  SHIFT_X2_SAT     = 2'h1;
    localparam logic [1:0]  SHIFT_X2_RAW     = 2'h2;
    localparam logic [1:0]  SHIFT_X1_RAW     = 2'h3;
    // =====================================================
    // field positions
    localparam int          FRAC_NI_LSB      = 11;
    localparam int          OFFS_NI_LSB      = 16;
    localparam int          OFFS_NI_BITS     = 7;
    localparam int          OFFS_IP_LSB      = 12;
    localparam logic [12:0] RING_MASK_MIN    = 13'h1FFF;
    // =====================================================
    // register map (byte offsets) and reset values
    localparam logic [7:0]  REG_CTRL         = 8'h00;
    localparam logic [7:0]  REG_STATUS       = 8'h04;
    localparam logic [7:0]  REG_FRACTION     = 8'h08;
    localparam logic [7:0]  REG_OFFSET       = 8'h0C;
    localparam logic [7:0]  REG_LAST_ADDR    = 8'h10;
    localparam logic [1:0]  RING_LEN_RST     = 2'h0;
    localparam int          STAT_CNT_LSB     = 16;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage : dsp_addr_pkg

// ===== shared/shift_if.sv
// link between the datapath top and its output shifter
interface shift_if #(parameter int ACC_W = 26);
    logic                    clk;
    logic signed [ACC_W-1:0] acc;
    logic        [1:0]       ctl;
    logic        [23:0]      result;
    modport src (output clk, output acc, output ctl, input result);
    modport shf (input clk, input acc, input ctl, output result);
endinterface : shift_if

// ===== hw/dsp_out_shifter.sv
// output shifter: gain of one or two with optional saturation
module dsp_out_shifter
    import dsp_addr_pkg::*;
#(
    parameter int ACC_W = 26
) (
    shift_if.shf sh
);
    // =====================================================
    // scaling and clamp
    localparam logic signed [ACC_W:0] POS_LIM = (ACC_W+1)'(2**(OUT_W-1) - 1);
    localparam logic signed [ACC_W:0] NEG_LIM = -(ACC_W+1)'(2**(OUT_W-1));

    wire                    gain2  = (sh.ctl == SHIFT_X2_SAT) || (sh.ctl == SHIFT_X2_RAW);
    wire                    sat_en = ~sh.ctl[1];
    wire signed [ACC_W:0]   ext    = {sh.acc[ACC_W-1], sh.acc};
    wire signed [ACC_W:0]   scaled = gain2 ? (ext <<< 1) : ext;
    wire                    ovf_p  = scaled > POS_LIM;
    wire                    ovf_n  = scaled < NEG_LIM;

    assign sh.result = (sat_en && ovf_p) ? POS_LIM[OUT_W-1:0] :
                       (sat_en && ovf_n) ? NEG_LIM[OUT_W-1:0] :
                       scaled[OUT_W-1:0];

    // a negative input under saturation must never come out non-negative
    a_sat_clamp: assert property (@(posedge sh.clk)
        (sat_en && sh.acc[ACC_W-1]) |-> sh.result[OUT_W-1])
        else $error("saturated negative result lost its sign");
endmodule : dsp_out_shifter

// ===== test/snd_mem_model.sv
// sound memory model: a 64K-word store that records each access of the datapath
module snd_mem_model
    import dsp_addr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [MADR_W-1:0] mem_addr,
    input  wire logic              mem_addr_valid,
    output int                     n_access
);
    timeunit 1ns;
    timeprecision 1ps;
    // =====================================================
    // storage and access log
    logic [15:0] words [0:65535]; // whole table space, no wrap below 64K words
    int count_r = 0;
    assign n_access = count_r;
    always @(posedge clk) begin
        if (mem_addr_valid === 1'b1) begin
            count_r <= count_r + 1;
            words[mem_addr] <= ~words[mem_addr];
        end
    end
endmodule : snd_mem_model

// ===== test/dsp_shift_and_delay_address_test.sv
// self-checking bench for the shifter, latches and sound-memory address path
module dsp_shift_and_delay_address_test
    import dsp_addr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int INIT_N = 16;
    // =====================================================
    // signals
    logic clk, sys_rst, step_valid, shift_ctl_hi, shift_ctl_lo, frac_latch_ctl, int_latch_ctl;
    logic offset_gate_bit, table_mode, next_word_increment, sample_tick, mem_addr_valid, init_done;
    logic [15:0] base_address_buffer, mem_addr, cnt_m;
    logic signed [25:0] accum_in;
    logic [23:0] input_operand, shifter_output, s_prev;
    logic [12:0] fraction_reg, fr_m;
    logic [11:0] address_offset_reg, off_m;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, ring_code;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_fail, checks_done, n_steps, n_access, i;
    dsp_shift_addr #(.ACC_W(26), .ADDR_W(8), .INIT_CYCLES(INIT_N)) dut (
        .clk, .sys_rst, .step_valid, .shift_ctl_hi, .shift_ctl_lo, .frac_latch_ctl, .int_latch_ctl,
        .offset_gate_bit, .table_mode, .next_word_increment, .base_address_buffer, .accum_in,
        .input_operand, .sample_tick, .shifter_output, .fraction_reg, .address_offset_reg, .mem_addr,
        .mem_addr_valid, .init_done, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    snd_mem_model mem (.clk, .mem_addr, .mem_addr_valid, .n_access);
    always #20 clk = ~clk;
    // =====================================================
    // expectations
    function automatic logic [15:0] mask();
        return (16'h2000 << ring_code) - 16'h1;
    endfunction : mask
    function automatic logic [23:0] shf_exp(logic [1:0] c, logic signed [25:0] a);
        logic signed [27:0] s;
        s = (c[1] ^ c[0]) ? (28'(a) <<< 1) : 28'(a);
        if (!c[1] && s > 28'sd8388607) return 24'h7FFFFF;
        if (!c[1] && s < -28'sd8388608) return 24'h800000;
        return s[23:0];
    endfunction : shf_exp
    function automatic logic [15:0] addr_exp(logic gt, tb, nx, logic [15:0] b);
        logic [15:0] r;
        r = b + (gt ? {{4{off_m[11]}}, off_m} : 16'h0) + 16'(nx);
        if (!tb) r = r & mask();
        r = r + (tb ? 16'h0 : cnt_m);
        if (!tb) r = r & mask();
        return r;
    endfunction : addr_exp
    // =====================================================
    // reporting
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    task automatic lost(input string what);
        n_fail++;
        $display("unexpected %s: expected an answer, seen none", what);
        end_of_test();
    endtask : lost
    // =====================================================
    // drivers
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        int n;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        b = 1'b0;
        for (n = 0; n < 50 && !b; n++) begin
            #1;
            aw = s_axi_awvalid && s_axi_awready === 1'b1;
            w = s_axi_wvalid && s_axi_wready === 1'b1;
            b = s_axi_bvalid === 1'b1;
            if (b) check("write response", 32'(er), 32'(s_axi_bresp));
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
        if (!b) lost("write response");
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, r;
        int n;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        r = 1'b0;
        for (n = 0; n < 50 && !r; n++) begin
            #1;
            ar = s_axi_arvalid && s_axi_arready === 1'b1;
            r = s_axi_rvalid === 1'b1;
            if (r) check("read response", 32'(er), 32'(s_axi_rresp));
            if (r) check("read data", ed, s_axi_rdata);
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
        end
        if (!r) lost("read response");
    endtask : axi_rd
    task automatic step(input logic [1:0] c, input logic fl, il, gt, tb, nx, input logic [15:0] b,
                        input logic signed [25:0] a, input logic [23:0] op);
        @(posedge clk);
        {shift_ctl_hi, shift_ctl_lo} <= c;
        {frac_latch_ctl, int_latch_ctl, offset_gate_bit, table_mode, next_word_increment} <= {fl, il, gt, tb, nx};
        base_address_buffer <= b;
        accum_in <= a;
        input_operand <= op;
        step_valid <= 1'b1;
        @(posedge clk);
        step_valid <= 1'b0;
        #1;
        n_steps++;
        check("step answer", 32'h1, 32'(mem_addr_valid));
        check("shifter", 32'(shf_exp(c, a)), 32'(shifter_output));
        check("address", 32'(addr_exp(gt, tb, nx, b)), 32'(mem_addr));
        if (fl) fr_m = (c == 2'h3) ? {1'b0, s_prev[11:0]} : s_prev[23:11];
        if (il) off_m = (c == 2'h3) ? s_prev[23:12] : {{5{op[23]}}, op[22:16]};
        check("fraction", 32'(fr_m), 32'(fraction_reg));
        check("offset", 32'(off_m), 32'(address_offset_reg));
        s_prev = shf_exp(c, a);
    endtask : step
    task automatic tick();
        @(posedge clk);
        sample_tick <= 1'b1;
        @(posedge clk);
        sample_tick <= 1'b0;
        cnt_m = (cnt_m == 16'h0) ? mask() : cnt_m - 16'h1;
    endtask : tick
    // =====================================================
    // scenarios
    task automatic s_regs();
        axi_rd(REG_CTRL, 32'h0, RESP_OKAY);
        axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
        axi_rd(REG_CTRL, 32'h3, RESP_OKAY);
        axi_wr(REG_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
        axi_rd(REG_STATUS, {cnt_m, 16'h1}, RESP_OKAY);
        axi_wr(8'h40, 32'h1, RESP_SLVERR);
        axi_rd(8'h40, 32'h0, RESP_SLVERR);
        axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    endtask : s_regs
    task automatic s_shift();
        logic signed [25:0] acc [3] = '{26'sh0C00000, -26'sh0C00000, 26'sh0123456};
        for (int c = 0; c < 4; c++)
            for (int k = 0; k < 3; k++)
                step(2'(c), 0, 0, 0, 1, 0, 16'h0, acc[k], 24'h0);
    endtask : s_shift
    task automatic s_latch();
        step(2'h0, 0, 0, 0, 1, 0, 16'h0, 26'sh02ABCDE, 24'h0);
        step(2'h0, 1, 1, 0, 1, 0, 16'h0, 26'sh0654321, 24'hC5_0000);
        step(2'h3, 1, 1, 0, 1, 0, 16'h0, 26'sh0000777, 24'h0);
        step(2'h2, 0, 0, 0, 1, 0, 16'h0, 26'sh0000001, 24'hFF_FFFF);
    endtask : s_latch
    task automatic s_addr();
        tick();
        tick();
        axi_rd(REG_STATUS, {cnt_m, 16'h1}, RESP_OKAY);
        step(2'h0, 0, 0, 0, 0, 1, 16'h1FFF, 26'sh0, 24'h0);
        step(2'h0, 0, 0, 1, 0, 0, 16'h0100, 26'sh0, 24'h0);
        step(2'h0, 0, 0, 0, 1, 1, 16'hFFFE, 26'sh0, 24'h0);
        step(2'h0, 0, 0, 1, 1, 0, 16'hF000, 26'sh0, 24'h0);
        for (int r = 1; r < 4; r++) begin
            axi_wr(REG_CTRL, 32'(r), RESP_OKAY);
            ring_code = 2'(r);
            step(2'h0, 0, 0, 0, 0, 1, 16'h3FFF, 26'sh0, 24'h0);
        end
        repeat (16'h1FFF) tick();
        axi_rd(REG_STATUS, {cnt_m, 16'h1}, RESP_OKAY);
        step(2'h0, 0, 0, 1, 0, 1, 16'hFFFF, 26'sh0, 24'h0);
        axi_rd(REG_LAST_ADDR, 32'(addr_exp(1, 0, 1, 16'hFFFF)), RESP_OKAY);
    endtask : s_addr
    // =====================================================
    // main sequence
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {step_valid, shift_ctl_hi, shift_ctl_lo, frac_latch_ctl, int_latch_ctl, offset_gate_bit} = '0;
        {table_mode, next_word_increment, sample_tick, base_address_buffer, accum_in, input_operand} = '0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, ring_code, cnt_m, s_prev, fr_m, off_m} = '0;
        {n_fail, checks_done, n_steps, i} = '0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        {step_valid, sample_tick} <= 2'b11;
        while (init_done !== 1'b1 && i < 40) begin
            @(posedge clk);
            if (i == INIT_N - 4) {step_valid, sample_tick} <= 2'b00;
            #1;
            i++;
        end
        check("init length", 32'h1, 32'(i >= INIT_N - 1 && i <= INIT_N + 2));
        s_regs();
        s_shift();
        s_latch();
        s_addr();
        check("memory accesses", 32'(n_steps), 32'(n_access));
        end_of_test();
    end
endmodule : dsp_shift_and_delay_address_test
